/* hw/cpp_pkg.sv */
package cpp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h800;
  localparam logic [11:0] REG_SHARP = 12'h804;
  localparam logic [11:0] REG_STAT = 12'h808;
  localparam logic [11:0] REG_HUE = 12'h810;
  localparam logic [11:0] REG_SAT = 12'h814;
  localparam logic [11:0] REG_COEF0 = 12'h820;
  localparam logic [11:0] REG_COEF_LAST = 12'h840;
  localparam int COEF_N = 9;

  // Control and status register fields.
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_CC_EN_BIT = 2;
  localparam int CTRL_SET_BIT = 3;
  localparam int STAT_REFUSED_BIT = 0;

  typedef enum logic [1:0] {
    CPP_FMT_YUV = 2'h0,
    CPP_FMT_RGB8 = 2'h1,
    CPP_FMT_RAW = 2'h2,
    CPP_FMT_RAW_ALT = 2'h3
  } cpp_fmt_t;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [8:0] HUE_NOM = 9'h080;
  localparam logic [8:0] HUE_MAX = 9'h100;
  localparam logic [8:0] SAT_NOM = 9'h100;
  localparam logic [2:0] SHARP_DEF = 3'h2;
  localparam logic [2:0] SHARP_MAX = 3'h4;
  localparam logic signed [31:0] COEF_UNITY = 32'sh000003E8;
  localparam logic signed [31:0] COEF_MIN = 32'shFFFFFC18;
  localparam logic signed [31:0] COEF_MAX = 32'sh000007D0;
  localparam logic signed [31:0] ROW_SUM_MAX = 32'sh000007D0;
  localparam logic [8:0][31:0] FACTORY_COEF = {
    COEF_UNITY, 32'h0, 32'h0,
    32'h0, COEF_UNITY, 32'h0,
    32'h0, 32'h0, COEF_UNITY};

  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  // Division by 1000 is done as a multiply by 1049 / 2^20.
  localparam logic signed [15:0] DIV_MUL = 16'sh0419;
  localparam int DIV_SH = 20;
  // Colour conversion weights scaled by 1024.
  localparam int YUV_SH = 10;
  localparam logic signed [11:0] Y_R = 12'sh133;
  localparam logic signed [11:0] Y_G = 12'sh25C;
  localparam logic signed [11:0] Y_B = 12'sh071;
  localparam logic signed [11:0] U_R = 12'shF53;
  localparam logic signed [11:0] U_G = 12'shEAE;
  localparam logic signed [11:0] U_B = 12'sh1FE;
  localparam logic signed [11:0] V_R = 12'sh1FE;
  localparam logic signed [11:0] V_G = 12'shE52;
  localparam logic signed [11:0] V_B = 12'shFAC;
  localparam logic signed [11:0] CHROMA_OFS = 12'sh080;
  // One hue step is 1/12.8 degree: sin ~ d*89/2^16, cos ~ 1-d*d*62/2^26.
  localparam logic signed [11:0] HUE_SIN_K = 12'sh059;
  localparam logic signed [11:0] HUE_COS_K = 12'sh03E;
  localparam int TRIG_SH = 16;
  localparam int COS_SH = 10;
  localparam logic signed [31:0] TRIG_ONE = 32'sh00010000;
  localparam int SAT_SH = 8;
  localparam int SHARP_SH = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
    logic [7:0] data;
  } cpp_pix_in_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
  } cpp_pix_out_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
    logic [7:0] raw;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } cpp_stg_t;

endpackage : cpp_pkg

/* hw/cpp_pipe.sv */
// Operation
// - RGB from 2x2 window, green averaged
// - First sensor pixel is red
// - RAW formats pass mosaic data untouched
// - Five-level three-tap horizontal luma sharpening
// - Sharpness ignored in RAW formats
// - Hue 0..256, 128 neutral, 1/12.8 degree
// - Saturation scales chroma in 1/256 steps
// - Hue and saturation ignored in RAW
// - Programmable 3x3 colour matrix after demosaic
// - Coefficient 1000 means unity gain
// - Signed 32-bit coefficients, -1000..2000 accepted
// - Row sums limited to 2000
// - Factory set 0 is write-protected
// - Matrix off in RAW or by control
// - Luma is 0.3R+0.59G+0.11B
// - RGB8 skips YUV conversion
// - Left/right border may be miscoloured
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module cpp_pipe
  import cpp_pkg::*;
#(
  parameter int MAX_W = 2048
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire cpp_pix_in_t pix_in,
  output cpp_pix_out_t pix_out
);

  localparam int XW = $clog2(MAX_W);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] sat8(input logic signed [63:0] v);
    sat8 = (v < 64'sh0) ? 8'h00 : ((v > 64'shFF) ? 8'hFF : v[7:0]);
  endfunction : sat8

  function automatic logic [7:0] ccm_row(
    input logic signed [31:0] k0,
    input logic signed [31:0] k1,
    input logic signed [31:0] k2,
    input logic [7:0] r,
    input logic [7:0] g,
    input logic [7:0] b);
    logic signed [63:0] s;
    s = 64'(k0) * $signed({1'b0, r}) + 64'(k1) * $signed({1'b0, g})
      + 64'(k2) * $signed({1'b0, b});
    ccm_row = sat8((s * 64'(DIV_MUL)) >>> DIV_SH);
  endfunction : ccm_row

  function automatic logic [7:0] lin3(
    input logic signed [11:0] k0,
    input logic signed [11:0] k1,
    input logic signed [11:0] k2,
    input logic [7:0] r,
    input logic [7:0] g,
    input logic [7:0] b,
    input logic signed [11:0] ofs);
    logic signed [63:0] s;
    s = 64'(k0) * $signed({1'b0, r}) + 64'(k1) * $signed({1'b0, g})
      + 64'(k2) * $signed({1'b0, b});
    lin3 = sat8((s >>> YUV_SH) + 64'(ofs));
  endfunction : lin3

  function automatic logic signed [31:0] row_sum(
    input logic [8:0][31:0] m,
    input int row);
    row_sum = $signed(m[row*3]) + $signed(m[row*3+1])
      + $signed(m[row*3+2]);
  endfunction : row_sum

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_q, rst_sync_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  cpp_fmt_t fmt_q, fmt_d;
  logic cc_en_q, cc_en_d;
  logic set_q, set_d;
  logic [2:0] sharp_q, sharp_d;
  logic [8:0] hue_q, hue_d, sat_q, sat_d;
  logic refused_q, refused_d;
  logic [8:0][31:0] user_q, user_d;
  logic [31:0] rdata_q, rdata_d;
  logic [8:0][31:0] coef, trial;
  logic coef_hit;
  logic [3:0] coef_idx;
  logic coef_ok;

  // Set 0 is the factory table, never stored in writable flops.
  assign coef = set_q ? user_q : FACTORY_COEF;

  always_comb begin
    fmt_d = fmt_q;
    cc_en_d = cc_en_q;
    set_d = set_q;
    sharp_d = sharp_q;
    hue_d = hue_q;
    sat_d = sat_q;
    refused_d = refused_q;
    user_d = user_q;
    rdata_d = 32'h0000_0000;
    coef_hit = (reg_addr >= REG_COEF0) && (reg_addr <= REG_COEF_LAST)
      && (reg_addr[1:0] == 2'h0);
    coef_idx = 4'((reg_addr - REG_COEF0) >> 2);
    trial = user_q;
    trial[coef_idx] = reg_wdata;
    coef_ok = set_q
      && ($signed(reg_wdata) >= COEF_MIN)
      && ($signed(reg_wdata) <= COEF_MAX)
      && (row_sum(trial, int'(coef_idx) / 3) <= ROW_SUM_MAX);
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          fmt_d = cpp_fmt_t'(reg_wdata[CTRL_FMT_LSB +: 2]);
          cc_en_d = reg_wdata[CTRL_CC_EN_BIT];
          set_d = reg_wdata[CTRL_SET_BIT];
        end
        REG_SHARP: begin
          if (reg_wdata[31:0] <= 32'(SHARP_MAX)) begin
            sharp_d = reg_wdata[2:0];
          end
        end
        REG_STAT: begin
          if (reg_wdata[STAT_REFUSED_BIT]) begin
            refused_d = 1'b0;
          end
        end
        REG_HUE: begin
          if (reg_wdata[31:0] <= 32'(HUE_MAX)) begin
            hue_d = reg_wdata[8:0];
          end
        end
        REG_SAT: begin
          sat_d = reg_wdata[8:0];
        end
        default: begin
          if (coef_hit) begin
            if (coef_ok) begin
              user_d = trial;
            end else begin
              refused_d = 1'b1;
            end
          end
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_d = {28'h0, set_q, cc_en_q, fmt_q};
        REG_SHARP: rdata_d = {29'h0, sharp_q};
        REG_STAT: rdata_d = {31'h0, refused_q};
        REG_HUE: rdata_d = {23'h0, hue_q};
        REG_SAT: rdata_d = {23'h0, sat_q};
        default: begin
          if (coef_hit) begin
            rdata_d = coef[coef_idx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fmt_q <= CPP_FMT_YUV;
      cc_en_q <= 1'b1;
      set_q <= 1'b0;
      sharp_q <= SHARP_DEF;
      hue_q <= HUE_NOM;
      sat_q <= SAT_NOM;
      refused_q <= 1'b0;
      user_q <= FACTORY_COEF;
      rdata_q <= 32'h0000_0000;
    end else begin
      fmt_q <= fmt_d;
      cc_en_q <= cc_en_d;
      set_q <= set_d;
      sharp_q <= sharp_d;
      hue_q <= hue_d;
      sat_q <= sat_d;
      refused_q <= refused_d;
      user_q <= user_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Demosaic with one line of memory
  // ----------------------------------------------------------------
  logic [7:0] line_mem [MAX_W];
  logic [XW-1:0] x_q, x_d, xi;
  logic y_odd_q, y_odd_d;
  logic first_q, first_d;
  logic [7:0] left_q, left_d, up_left_q, up_left_d;
  cpp_stg_t s1_q, s1_d;
  logic [7:0] up;
  logic [8:0] gsum;
  logic is_raw;

  assign is_raw = fmt_q[1];

  always_comb begin
    xi = pix_in.sol ? '0 : x_q;
    y_odd_d = pix_in.sof ? 1'b0 : (pix_in.sol ? ~y_odd_q : y_odd_q);
    first_d = pix_in.sof ? 1'b1 : (pix_in.sol ? 1'b0 : first_q);
    // The top line has nothing above it, so it is reused as its own.
    up = first_d ? pix_in.data : line_mem[xi];
    x_d = x_q;
    left_d = left_q;
    up_left_d = up_left_q;
    if (!pix_in.valid) begin
      y_odd_d = y_odd_q;
      first_d = first_q;
    end else begin
      x_d = xi + 1'b1;
      left_d = pix_in.data;
      up_left_d = up;
    end
    s1_d = '0;
    s1_d.valid = pix_in.valid;
    s1_d.sof = pix_in.sof;
    s1_d.sol = pix_in.sol;
    s1_d.raw = pix_in.data;
    gsum = 9'h000;
    // Window corners: up_left_q, up, left_q, data. Red sits at even
    // line and even column, blue at odd and odd. Column 0 pairs with the
    // end of the line before, which gives the edge tint.
    case ({y_odd_d, xi[0]})
      2'b11: begin
        s1_d.a = up_left_q;
        s1_d.c = pix_in.data;
        gsum = up + left_q;
      end
      2'b10: begin
        s1_d.a = up;
        s1_d.c = left_q;
        gsum = up_left_q + pix_in.data;
      end
      2'b01: begin
        s1_d.a = left_q;
        s1_d.c = up;
        gsum = up_left_q + pix_in.data;
      end
      default: begin
        s1_d.a = pix_in.data;
        s1_d.c = up_left_q;
        gsum = up + left_q;
      end
    endcase
    s1_d.b = gsum[8:1];
  end

  always_ff @(posedge clk_sys) begin
    if (pix_in.valid) begin
      line_mem[xi] <= pix_in.data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      x_q <= '0;
      y_odd_q <= 1'b0;
      first_q <= 1'b1;
      left_q <= 8'h00;
      up_left_q <= 8'h00;
      s1_q <= '0;
    end else begin
      x_q <= x_d;
      y_odd_q <= y_odd_d;
      first_q <= first_d;
      left_q <= left_d;
      up_left_q <= up_left_d;
      s1_q <= s1_d;
    end
  end

  // ----------------------------------------------------------------
  // Matrix, conversion, hue/saturation, sharpening
  // ----------------------------------------------------------------
  // Each stage is one register, so the pipe is five cycles deep in
  // every format; markers ride along with the raw sample.
  cpp_stg_t s2_q, s2_d, s3_q, s3_d, s4_q, s4_d;
  cpp_pix_out_t out_q, out_d;
  logic [7:0] yl_q, yl_d;
  logic signed [31:0] hd, sn, cs, du, dv;
  logic signed [63:0] ru, rv, ys;
  logic signed [5:0] tap_side, tap_cen;

  always_comb begin
    // Colour matrix.
    s2_d = s1_q;
    if (cc_en_q && !is_raw) begin
      s2_d.a = ccm_row(coef[0], coef[1], coef[2], s1_q.a, s1_q.b, s1_q.c);
      s2_d.b = ccm_row(coef[3], coef[4], coef[5], s1_q.a, s1_q.b, s1_q.c);
      s2_d.c = ccm_row(coef[6], coef[7], coef[8], s1_q.a, s1_q.b, s1_q.c);
    end
    // Colour space conversion.
    s3_d = s2_q;
    if (fmt_q == CPP_FMT_YUV) begin
      s3_d.a = lin3(Y_R, Y_G, Y_B, s2_q.a, s2_q.b, s2_q.c,
        12'sh000);
      s3_d.b = lin3(U_R, U_G, U_B, s2_q.a, s2_q.b, s2_q.c,
        CHROMA_OFS);
      s3_d.c = lin3(V_R, V_G, V_B, s2_q.a, s2_q.b, s2_q.c, CHROMA_OFS);
    end
    // Chroma rotation and gain; small-angle sine and cosine are exact
    // to a fraction of a code over the +/-10 degree range.
    s4_d = s3_q;
    hd = $signed({23'h0, hue_q}) - $signed({23'h0, HUE_NOM});
    sn = hd * 32'(HUE_SIN_K);
    cs = TRIG_ONE - ((hd * hd * 32'(HUE_COS_K)) >>> COS_SH);
    du = $signed({24'h0, s3_q.b}) - 32'(CHROMA_OFS);
    dv = $signed({24'h0, s3_q.c}) - 32'(CHROMA_OFS);
    ru = (64'(du) * 64'(cs) - 64'(dv) * 64'(sn)) >>> TRIG_SH;
    rv = (64'(du) * 64'(sn) + 64'(dv) * 64'(cs)) >>> TRIG_SH;
    ru = (ru * $signed({55'h0, sat_q})) >>> SAT_SH;
    rv = (rv * $signed({55'h0, sat_q})) >>> SAT_SH;
    if (fmt_q == CPP_FMT_YUV) begin
      s4_d.b = sat8(ru + 64'(CHROMA_OFS));
      s4_d.c = sat8(rv + 64'(CHROMA_OFS));
    end
    // Luma sharpening over left, centre and right samples, taps x8.
    case (sharp_q)
      3'h0: {tap_side, tap_cen} = {6'sh02, 6'sh04};
      3'h1: {tap_side, tap_cen} = {6'sh01, 6'sh06};
      3'h3: {tap_side, tap_cen} = {-6'sh02, 6'sh0C};
      3'h4: {tap_side, tap_cen} = {-6'sh04, 6'sh10};
      default: {tap_side, tap_cen} = {6'sh00, 6'sh08};
    endcase
    ys = (64'(tap_side) * $signed({56'h0, yl_q})
      + 64'(tap_cen) * $signed({56'h0, s4_q.a})
      + 64'(tap_side) * $signed({56'h0, s3_q.a})) >>> SHARP_SH;
    yl_d = s4_q.a;
    out_d.valid = s4_q.valid;
    out_d.sof = s4_q.sof;
    out_d.sol = s4_q.sol;
    out_d.c0 = s4_q.a;
    out_d.c1 = s4_q.b;
    out_d.c2 = s4_q.c;
    if (is_raw) begin
      out_d.c0 = s4_q.raw;
      out_d.c1 = 8'h00;
      out_d.c2 = 8'h00;
    end else if (fmt_q == CPP_FMT_YUV) begin
      out_d.c0 = sat8(ys);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s2_q <= '0;
      s3_q <= '0;
      s4_q <= '0;
      yl_q <= 8'h00;
      out_q <= '0;
    end else begin
      s2_q <= s2_d;
      s3_q <= s3_d;
      s4_q <= s4_d;
      yl_q <= yl_d;
      out_q <= out_d;
    end
  end

  assign pix_out = out_q;

endmodule : cpp_pipe

/* dv/cpp_pipe_assertions.sv */
`timescale 1ns/1ns
module cpp_pipe_assertions
  import cpp_pkg::*;
#(
  parameter int MAX_W = 2048
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire cpp_pix_in_t pix_in,
  input wire cpp_pix_out_t pix_out
);
  // ------------------------------------------------------------
  // Shadow copy of the settings that shape the output
  // ------------------------------------------------------------
  logic [1:0] fmt_q, fmt_d;
  logic [8:0] hue_q, hue_d, sat_q, sat_d;
  logic raw, grey;
  always_comb begin
    fmt_d = fmt_q;
    hue_d = hue_q;
    sat_d = sat_q;
    if (reg_wr && reg_addr == REG_CTRL) fmt_d = reg_wdata[1:0];
    if (reg_wr && reg_addr == REG_SAT) sat_d = reg_wdata[8:0];
    if (reg_wr && reg_addr == REG_HUE && reg_wdata <= 32'h00000100)
      hue_d = reg_wdata[8:0];
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fmt_q <= 2'h0;
      hue_q <= HUE_NOM;
      sat_q <= SAT_NOM;
    end else begin
      fmt_q <= fmt_d;
      hue_q <= hue_d;
      sat_q <= sat_d;
    end
  end
  assign raw = fmt_q[1];
  assign grey = fmt_q == 2'h0 && sat_q == 9'h000;

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_lat;
    pix_in.valid |-> ##5 pix_out.valid;
  endproperty
  a_lat: assert property (p_lat) else $error("pixel lost");
  property p_nospur;
    pix_out.valid |-> $past(pix_in.valid, 5);
  endproperty
  a_nospur: assert property (p_nospur)
    else $error("pixel without input");
  property p_mark;
    pix_out.valid |-> pix_out.sof == $past(pix_in.sof, 5)
      && pix_out.sol == $past(pix_in.sol, 5);
  endproperty
  a_mark: assert property (p_mark) else $error("marker moved");
  property p_raw;
    (pix_in.valid && raw) ##5 raw |-> pix_out.c0 == $past(pix_in.data, 5);
  endproperty
  a_raw: assert property (p_raw)
    else $error("raw sample altered");
  property p_rawc;
    (pix_in.valid && raw) ##5 raw |-> pix_out.c1 == 8'h00
      && pix_out.c2 == 8'h00;
  endproperty
  a_rawc: assert property (p_rawc) else $error("raw chroma");
  property p_grey;
    (pix_in.valid && grey) ##5 grey |-> pix_out.c1 == 8'h80
      && pix_out.c2 == 8'h80;
  endproperty
  a_grey: assert property (p_grey) else $error("not grey");
  property p_hue;
    reg_rd && reg_addr == REG_HUE |=> reg_rdata == {23'h000000, hue_q};
  endproperty
  a_hue: assert property (p_hue) else $error("hue readback");
  property p_sat;
    reg_rd && reg_addr == REG_SAT |=> reg_rdata == {23'h000000, sat_q};
  endproperty
  a_sat: assert property (p_sat) else $error("sat readback");
  c_raw: cover property (raw && pix_out.valid);
  c_grey: cover property (grey && pix_out.valid);
  c_hue: cover property (reg_wr && reg_addr == REG_HUE
    && reg_wdata > 32'h00000100);
endmodule : cpp_pipe_assertions

bind cpp_pipe cpp_pipe_assertions #(.MAX_W(MAX_W)) cpp_pipe_assertions_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out));

/* dv/cpp_sensor_model.sv */
`timescale 1ns/1ns
module cpp_sensor_model
  import cpp_pkg::*;
#(
  parameter int W = 16,
  parameter int H = 4
) (
  input wire logic clk_sys,
  output cpp_pix_in_t pix
);
  // ------------------------------------------------------------
  // Flat colour frame, lines back to back
  // ------------------------------------------------------------
  initial pix = '0;
  task automatic frame(input logic [7:0] r, g, b);
    logic [7:0] v;
    for (int y = 0; y < H; y++) begin
      for (int x = 0; x < W; x++) begin
        if (y[0] == 1'b0) v = x[0] ? g : r;
        else v = x[0] ? b : g;
        @(posedge clk_sys);
        pix.valid <= 1'b1;
        pix.sof <= x == 0 && y == 0;
        pix.sol <= x == 0;
        pix.data <= v;
      end
    end
    @(posedge clk_sys);
    pix.valid <= 1'b0;
    pix.sof <= 1'b0;
    pix.sol <= 1'b0;
    // Idle data is scrambled so stale samples cannot look valid.
    pix.data <= ~v;
  endtask : frame
endmodule : cpp_sensor_model

/* dv/cpp_pipe_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g, tol) \
  begin \
    n_checks++; \
    if ((^(g)) === 1'bx || ((e) > (g) ? (e) - (g) : (g) - (e)) > (tol)) begin \
      errors++; \
      $display("[FAIL] %s exp %0d got %0d", nm, e, g); \
    end \
  end
module cpp_pipe_tb_top
  import cpp_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  cpp_pix_in_t pix_in;
  cpp_pix_out_t pix_out;
  logic [7:0] o0 [4][16];
  logic [7:0] o1 [4][16];
  logic [7:0] o2 [4][16];
  int row, col, errors, n_checks;

  always #50 clk_sys = ~clk_sys;

  cpp_pipe #(.MAX_W(16)) cpp_pipe_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pix_in),
    .pix_out(pix_out));
  cpp_sensor_model #(.W(16), .H(4)) cpp_sensor_model_i (
    .clk_sys(clk_sys), .pix(pix_in));

  // ------------------------------------------------------------
  // Output capture, placed by the carried markers
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (pix_out.valid === 1'b1) begin
      if (pix_out.sof) row = 0;
      else if (pix_out.sol) row++;
      col = pix_out.sol ? 0 : col + 1;
      if (row < 4 && col < 16) begin
        o0[row][col] = pix_out.c0;
        o1[row][col] = pix_out.c1;
        o2[row][col] = pix_out.c2;
      end
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic close_out;
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata, 0)
  endtask : rd_chk
  task automatic shoot(input logic [7:0] r, g, b);
    cpp_sensor_model_i.frame(r, g, b);
    repeat (8) @(posedge clk_sys);
  endtask : shoot
  // Edge columns are skipped: the border tint there is permitted.
  task automatic pix_chk(input string nm, input int e0, e1, e2, tol);
    for (int y = 1; y < 4; y++) begin
      for (int x = 2; x < 14; x++) begin
        `CHK(nm, e0, o0[y][x], tol)
        `CHK(nm, e1, o1[y][x], tol)
        `CHK(nm, e2, o2[y][x], tol)
      end
    end
  endtask : pix_chk
  function automatic int clip(input real x);
    return x > 255.0 ? 255 : (x < 0.0 ? 0 : int'(x));
  endfunction : clip
  task automatic yuv(input int r, g, b, hue, sat, tol);
    real u0, v0, a;
    u0 = -0.169 * r - 0.33 * g + 0.498 * b;
    v0 = 0.498 * r - 0.420 * g - 0.082 * b;
    a = (hue - 128) / 12.8 * 3.14159265 / 180.0;
    shoot(r[7:0], g[7:0], b[7:0]);
    pix_chk("yuv", clip(0.3 * r + 0.59 * g + 0.11 * b),
      clip(128.0 + (u0 * $cos(a) - v0 * $sin(a)) * sat / 256.0),
      clip(128.0 + (u0 * $sin(a) + v0 * $cos(a)) * sat / 256.0), tol);
  endtask : yuv

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd_chk("ctrl", REG_CTRL, 32'h00000004);
    rd_chk("sharp", REG_SHARP, 32'h00000002);
    rd_chk("hue", REG_HUE, 32'h00000080);
    rd_chk("sat", REG_SAT, 32'h00000100);
    rd_chk("stat", REG_STAT, 32'h00000000);
    rd_chk("coef0", REG_COEF0, 32'h000003E8);
    rd_chk("coef1", REG_COEF0 + 12'h004, 32'h00000000);
    wr(12'h8FC, 32'hFFFFFFFF);
    rd_chk("unmapped", 12'h8FC, 32'h00000000);
  endtask : t_regs
  task automatic t_yuv;
    yuv(200, 100, 50, 128, 256, 2);
    for (int l = 0; l < 5; l++) begin
      wr(REG_SHARP, 32'(l));
      yuv(90, 160, 220, 128, 256, 2);
    end
    wr(REG_SHARP, 32'h00000005);
    rd_chk("sharp", REG_SHARP, 32'h00000004);
    wr(REG_SHARP, 32'h00000002);
  endtask : t_yuv
  task automatic t_huesat;
    wr(REG_SAT, 32'h00000000);
    yuv(200, 100, 50, 128, 0, 1);
    wr(REG_SAT, 32'h000001FF);
    yuv(200, 100, 50, 128, 511, 2);
    yuv(255, 0, 0, 128, 511, 2);
    wr(REG_SAT, 32'h00000100);
    wr(REG_HUE, 32'h00000100);
    yuv(200, 100, 50, 256, 256, 3);
    wr(REG_HUE, 32'h00000101);
    rd_chk("hue", REG_HUE, 32'h00000100);
    wr(REG_HUE, 32'h00000000);
    yuv(200, 100, 50, 0, 256, 3);
    wr(REG_HUE, 32'h00000080);
  endtask : t_huesat
  task automatic t_matrix;
    wr(REG_CTRL, 32'h00000005);
    shoot(8'hC8, 8'h64, 8'h32);
    pix_chk("rgb", 200, 100, 50, 1);
    wr(REG_COEF0, 32'h00000000);
    rd_chk("stat", REG_STAT, 32'h00000001);
    rd_chk("coef0", REG_COEF0, 32'h000003E8);
    wr(REG_STAT, 32'h00000001);
    wr(REG_CTRL, 32'h0000000D);
    wr(REG_COEF0, 32'h00000000);
    wr(REG_COEF0 + 12'h008, 32'h000003E8);
    wr(REG_COEF0 + 12'h018, 32'h000003E8);
    wr(REG_COEF0 + 12'h020, 32'h00000000);
    rd_chk("stat", REG_STAT, 32'h00000000);
    shoot(8'hC8, 8'h64, 8'h32);
    pix_chk("swap", 50, 100, 200, 1);
    wr(REG_COEF0, 32'h000007D1);
    wr(REG_COEF0 + 12'h004, 32'hFFFFFC17);
    wr(REG_COEF0 + 12'h00C, 32'h000005DC);
    rd_chk("stat", REG_STAT, 32'h00000001);
    rd_chk("coef0", REG_COEF0, 32'h00000000);
    rd_chk("coef1", REG_COEF0 + 12'h004, 32'h00000000);
    rd_chk("coef3", REG_COEF0 + 12'h00C, 32'h00000000);
    wr(REG_COEF0, 32'h000003E8);
    shoot(8'hC8, 8'h64, 8'h64);
    pix_chk("clamp", 255, 100, 200, 1);
    wr(REG_CTRL, 32'h00000009);
    shoot(8'hC8, 8'h64, 8'h32);
    pix_chk("cc_off", 200, 100, 50, 1);
    wr(REG_CTRL, 32'h00000008);
    yuv(200, 100, 50, 128, 256, 2);
  endtask : t_matrix
  task automatic t_raw;
    wr(REG_SHARP, 32'h00000004);
    wr(REG_HUE, 32'h00000000);
    wr(REG_SAT, 32'h000001FF);
    for (int f = 2; f < 4; f++) begin
      wr(REG_CTRL, 32'h0000000C | 32'(f));
      shoot(8'hC8, 8'h64, 8'h32);
      `CHK("raw_r", 200, o0[2][2], 0)
      `CHK("raw_g", 100, o0[1][2], 0)
      `CHK("raw_b", 50, o0[1][3], 0)
      `CHK("raw_u", 0, o1[1][3], 0)
    end
  endtask : t_raw

  initial begin
    #1_000_000;
    errors++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_yuv();
    t_huesat();
    t_matrix();
    t_raw();
    close_out();
  end
endmodule : cpp_pipe_tb_top
